// [core/mio_top.sv]
// Contract
// - first twelve digital inputs may each be enabled as a fast pulse counter
// - any digital input change can raise an event independent of the scan
// - relay command versus back indication disagreement is readable status
// - inhibit open: non-latching relays off, latching relays hold their state
// - mismatch reports are suppressed while relays are inhibited
// - current relay inhibit state is readable by the CPU
// - each analog result is a 16-bit signed value including sign
// - mains rejection per module: 50 Hz gives 10 ms, 60 Hz 8.3 ms sampling
// - running average over 1, 2, 4 ... 128 samples, chosen per module
// - analog values read as raw counts or scaled engineering units
// - sleep stops the module; io reads return preset substitute values
// - module failure lights error led, emits event, shows readable status
// - input debounce filter 0 to 51.0 ms in 0.2 ms steps
// - counter inputs have their own filter 0 to 12.75 ms in 0.05 ms steps
// - counters follow pulses up to 5 kHz with 100 us widths
// - input changes are time tagged at 1 ms and raise an event
// - on CPU failure each relay goes on, off or holds per config
// - sixteen digital inputs, four changeover relays, four analog inputs
// - under-range and over-range flag per analog input, each drives an led
`timescale 1ns/10ps
module mio_top #(
   parameter int TICK_CYC = mio_pkg::TICK_CYC,
   parameter int NUM_DI = 16,
   parameter int NUM_CNT = 12,
   parameter int NUM_RELAY = 4,
   parameter int NUM_AI = 4
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [15:0] di_raw,
   input wire logic [3:0] relay_back,
   input wire logic relay_power_inhibit_input,
   input wire logic cpu_fail,
   input wire logic module_fault,
   input wire logic [3:0][15:0] adc_data,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic [3:0] relay_drive,
   output logic err_led,
   output logic fail_event,
   output logic cos_event,
   output logic [3:0] under_range_flag,
   output logic [3:0] over_range_flag
);
   // ==========================================================================
   // elaboration checks: port widths fix the channel counts
   if (NUM_DI != 16 || NUM_CNT != 12 || NUM_RELAY != 4 || NUM_AI != 4) begin : g_bad_count
      $error("channel counts are fixed by the port widths");
   end
   if (TICK_CYC < 1 || TICK_CYC > 16383) begin : g_bad_tick
      $error("TICK_CYC must lie in 1..16383");
   end

   typedef struct packed {
      logic sleep;
      logic mains60;
      logic [2:0] avg_sel;
      logic egu_en;
      logic latching;
      logic [7:0] di_filt;
      logic [7:0] cnt_filt;
      logic [11:0] cnt_en;
      logic [3:0] relay_cmd;
      logic [7:0] fail_state;
      logic [15:0] subst;
      logic signed [15:0] gain;
      logic signed [15:0] offs;
      logic signed [15:0] lo_lim;
      logic signed [15:0] hi_lim;
      logic [15:0] di_state;
      logic [11:0] cnt_prev;
      logic [11:0][15:0] count;
      logic [15:0] cos_flags;
      logic [15:0] stamp;
      logic [3:0] evt_idx;
      logic [15:0] evt_stamp;
      logic [13:0] tick_cnt;
      logic [1:0] div_di;
      logic [4:0] div_ms;
      logic [7:0] smp_cnt;
      logic [6:0] wr_ptr;
      logic [7:0] fill;
      logic [2:0] avg_prev;
      logic [3:0][23:0] sum;
      logic [3:0][15:0] ai_val;
      logic [3:0] relay_drive;
      logic [3:0] mismatch;
      logic inhibited;
      logic fail;
      logic fail_event;
      logic cos_event;
      logic [3:0] under;
      logic [3:0] over;
      logic [31:0] rdata;
   } mio_state_type;

   mio_state_type q_ff;
   mio_state_type nxt_q;

   // averaging history: 128 samples per channel, no reset needed since fill gates reads
   logic [15:0] hist [4][128];

   logic tick;
   logic tick_di;
   logic smp;
   logic smp_due;
   logic [15:0] di_lvl;
   logic [11:0] cnt_lvl;

   // ==========================================================================
   // time base: 50 us tick, 0.2 ms debounce step, 1 ms time stamp
   assign tick = (q_ff.tick_cnt == 14'(TICK_CYC - 1));
   assign tick_di = tick && (q_ff.div_di == 2'(mio_pkg::DI_STEP_TICKS - 1));
   // period counter rolls over even asleep, and >= catches a switch to the shorter period
   assign smp_due = tick &&
      (q_ff.smp_cnt >= (q_ff.mains60 ? mio_pkg::SMP60_TICKS : mio_pkg::SMP50_TICKS) - 8'h01);
   assign smp = smp_due && !q_ff.sleep;

   // ==========================================================================
   // input filters: debounce on all inputs, separate counter filter on the first twelve
   for (genvar i = 0; i < NUM_DI; i++) begin : g_di
      mio_debounce u_di (
         .mclk(mclk),
         .rst(rst),
         .tick(tick_di),
         .raw(di_raw[i]),
         .limit(q_ff.di_filt),
         .level(di_lvl[i])
      );
      if (i < NUM_CNT) begin : g_cnt
         mio_debounce u_cnt (
            .mclk(mclk),
            .rst(rst),
            .tick(tick),
            .raw(di_raw[i]),
            .limit(q_ff.cnt_filt),
            .level(cnt_lvl[i])
         );
      end
   end

   // ==========================================================================
   // relay fail-state decode, shared by every relay
   function automatic logic mio_fail_level(input logic [1:0] mode, input logic last);
      if (mode == mio_pkg::FAIL_OFF) begin
         return 1'b0;
      end else if (mode == mio_pkg::FAIL_ON) begin
         return 1'b1;
      end
      return last;                                // hold code and the spare code keep last value
   endfunction : mio_fail_level

   // ==========================================================================
   // next-state logic for the whole module
   always_comb begin
      logic [15:0] chg;
      logic [11:0] rise;
      logic [7:0] len;
      logic signed [23:0] acc;
      logic signed [15:0] avg;
      logic signed [31:0] prod;
      logic [15:0] old;
      logic [31:0] rv;
      chg = 16'h0000;
      rise = 12'h000;
      len = 8'h01 << q_ff.avg_sel;
      acc = 24'sh000000;
      avg = 16'sh0000;
      prod = 32'sh00000000;
      old = 16'h0000;
      rv = 32'h00000000;
      nxt_q = q_ff;

      // time base counters run even in sleep so the stamp stays meaningful
      nxt_q.tick_cnt = tick ? 14'h0000 : q_ff.tick_cnt + 14'h0001;
      if (tick) begin
         nxt_q.div_di = q_ff.div_di + 2'h1;
         nxt_q.div_ms = (q_ff.div_ms == 5'(mio_pkg::STAMP_TICKS - 1)) ? 5'h00 : q_ff.div_ms + 5'h01;
         if (q_ff.div_ms == 5'(mio_pkg::STAMP_TICKS - 1)) begin
            nxt_q.stamp = q_ff.stamp + 16'h0001;  // 1 ms resolution
         end
         nxt_q.smp_cnt = smp_due ? 8'h00 : q_ff.smp_cnt + 8'h01;
      end

      // register writes
      if (reg_wr) begin
         unique case (reg_addr)
            mio_pkg::OFS_CTRL: begin
               nxt_q.sleep = reg_wdata[mio_pkg::CTRL_SLEEP];
               nxt_q.mains60 = reg_wdata[mio_pkg::CTRL_MAINS60];
               nxt_q.avg_sel = reg_wdata[mio_pkg::CTRL_AVG_LSB +: 3];
               nxt_q.egu_en = reg_wdata[mio_pkg::CTRL_EGU];
               nxt_q.latching = reg_wdata[mio_pkg::CTRL_LATCHING];
            end
            mio_pkg::OFS_FILT: begin
               nxt_q.di_filt = reg_wdata[7:0];
               nxt_q.cnt_filt = reg_wdata[15:8];
            end
            mio_pkg::OFS_CNT_EN: nxt_q.cnt_en = reg_wdata[11:0];
            mio_pkg::OFS_RELAY_CMD: nxt_q.relay_cmd = reg_wdata[3:0];
            mio_pkg::OFS_FAIL_STATE: nxt_q.fail_state = reg_wdata[7:0];
            mio_pkg::OFS_COS_FLAGS: nxt_q.cos_flags = q_ff.cos_flags & ~reg_wdata[15:0];
            mio_pkg::OFS_SUBST: nxt_q.subst = reg_wdata[15:0];
            mio_pkg::OFS_SCALE: begin
               nxt_q.gain = reg_wdata[15:0];
               nxt_q.offs = reg_wdata[31:16];
            end
            mio_pkg::OFS_RANGE: begin
               nxt_q.lo_lim = reg_wdata[15:0];
               nxt_q.hi_lim = reg_wdata[31:16];
            end
            default: ;
         endcase
      end

      // digital inputs, change of state and counters freeze while asleep
      if (!q_ff.sleep) begin
         chg = di_lvl ^ q_ff.di_state;
         nxt_q.di_state = di_lvl;
         nxt_q.cos_flags = nxt_q.cos_flags | chg;                                // set beats clear
         for (int i = 15; i >= 0; i--) begin
            if (chg[i]) begin
               nxt_q.evt_idx = 4'(i);
            end
         end
         if (chg != 16'h0000) begin
            nxt_q.evt_stamp = q_ff.stamp;
         end
         rise = cnt_lvl & ~q_ff.cnt_prev & q_ff.cnt_en;
         nxt_q.cnt_prev = cnt_lvl;
         for (int i = 0; i < 12; i++) begin
            if (rise[i]) begin
               nxt_q.count[i] = q_ff.count[i] + 16'h0001;                        // one edge per cycle is ample
            end
         end
      end
      nxt_q.cos_event = (nxt_q.cos_flags != 16'h0000);

      // analog averaging, scaling and range flags
      if (q_ff.avg_sel != q_ff.avg_prev) begin
         nxt_q.avg_prev = q_ff.avg_sel;           // new length: restart the window cleanly
         nxt_q.sum = '0;
         nxt_q.fill = 8'h00;
      end else if (smp) begin
         nxt_q.wr_ptr = q_ff.wr_ptr + 7'h01;
         nxt_q.fill = (q_ff.fill == 8'h80) ? q_ff.fill : q_ff.fill + 8'h01;
         for (int c = 0; c < 4; c++) begin
            old = (q_ff.fill >= len) ? hist[c][7'(q_ff.wr_ptr - len[6:0])] : 16'h0000;
            acc = $signed(q_ff.sum[c]) + 24'($signed(adc_data[c])) - 24'($signed(old));
            nxt_q.sum[c] = acc;
            avg = 16'(acc >>> q_ff.avg_sel);                                     // 16-bit signed
            prod = 32'(avg) * 32'(q_ff.gain);
            nxt_q.ai_val[c] = q_ff.egu_en ? 16'(32'(prod >>> 8) + 32'(q_ff.offs)) : avg;
            nxt_q.under[c] = (avg < q_ff.lo_lim);
            nxt_q.over[c] = (avg > q_ff.hi_lim);
         end
      end

      // relays: inhibit first, then CPU fail, then command
      nxt_q.inhibited = relay_power_inhibit_input;
      for (int r = 0; r < 4; r++) begin
         if (relay_power_inhibit_input) begin
            nxt_q.relay_drive[r] = q_ff.latching ? q_ff.relay_drive[r] : 1'b0;
         end else if (cpu_fail) begin
            nxt_q.relay_drive[r] = mio_fail_level(q_ff.fail_state[2*r +: 2], q_ff.relay_drive[r]);
         end else begin
            nxt_q.relay_drive[r] = q_ff.relay_cmd[r];
         end
      end
      // mismatch is a live level so a cleared fault disappears by itself
      nxt_q.mismatch = relay_power_inhibit_input ? 4'h0 : (q_ff.relay_drive ^ relay_back);

      // module failure is sticky until reset
      nxt_q.fail = q_ff.fail | module_fault;
      nxt_q.fail_event = module_fault & ~q_ff.fail;

      // read mux, data stand for exactly one cycle after the strobe
      if (reg_rd) begin
         unique case (reg_addr)
            mio_pkg::OFS_CTRL: rv = {25'h0, q_ff.latching, q_ff.egu_en, q_ff.avg_sel, q_ff.mains60, q_ff.sleep};
            mio_pkg::OFS_FILT: rv = {16'h0, q_ff.cnt_filt, q_ff.di_filt};
            mio_pkg::OFS_CNT_EN: rv = {20'h0, q_ff.cnt_en};
            mio_pkg::OFS_RELAY_CMD: rv = {28'h0, q_ff.relay_cmd};
            mio_pkg::OFS_FAIL_STATE: rv = {24'h0, q_ff.fail_state};
            mio_pkg::OFS_STATUS: rv = {17'h0, cpu_fail, q_ff.over, q_ff.under, q_ff.fail, q_ff.inhibited,
               q_ff.mismatch};
            mio_pkg::OFS_DI_STATE: rv = q_ff.sleep ? {16'h0, q_ff.subst} : {16'h0, q_ff.di_state};
            mio_pkg::OFS_COS_FLAGS: rv = {16'h0, q_ff.cos_flags};
            mio_pkg::OFS_EVENT: rv = {12'h0, q_ff.evt_idx, q_ff.evt_stamp};
            mio_pkg::OFS_SUBST: rv = {16'h0, q_ff.subst};
            mio_pkg::OFS_SCALE: rv = {q_ff.offs, q_ff.gain};
            mio_pkg::OFS_RANGE: rv = {q_ff.hi_lim, q_ff.lo_lim};
            mio_pkg::OFS_RELAY_STATE: rv = q_ff.sleep ? {16'h0, q_ff.subst} : {24'h0, relay_back, q_ff.relay_drive};
            default: begin
               if (reg_addr[7:6] == mio_pkg::OFS_COUNT_PAGE && reg_addr[5:2] < 4'hc && reg_addr[1:0] == 2'h0) begin
                  rv = {16'h0, q_ff.sleep ? q_ff.subst : q_ff.count[reg_addr[5:2]]};
               end else if (reg_addr[7:4] == mio_pkg::OFS_AI_PAGE && reg_addr[1:0] == 2'h0) begin
                  rv = {16'h0, q_ff.sleep ? q_ff.subst : q_ff.ai_val[reg_addr[3:2]]};
               end
            end
         endcase
      end
      nxt_q.rdata = rv;
   end

   // ==========================================================================
   // state register and history memory
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         q_ff <= '0;
         q_ff.gain <= mio_pkg::RST_GAIN;
         q_ff.lo_lim <= mio_pkg::RST_LO_LIM;
         q_ff.hi_lim <= mio_pkg::RST_HI_LIM;
         q_ff.di_filt <= mio_pkg::RST_FILT;
         q_ff.cnt_filt <= mio_pkg::RST_FILT;
      end else begin
         q_ff <= nxt_q;
      end
   end

   always_ff @(posedge mclk) begin
      if (smp && q_ff.avg_sel == q_ff.avg_prev) begin
         for (int c = 0; c < 4; c++) begin
            hist[c][q_ff.wr_ptr] <= adc_data[c];
         end
      end
   end

   assign reg_rdata = q_ff.rdata;
   assign relay_drive = q_ff.relay_drive;
   assign err_led = q_ff.fail;
   assign fail_event = q_ff.fail_event;
   assign cos_event = q_ff.cos_event;
   assign under_range_flag = q_ff.under;
   assign over_range_flag = q_ff.over;

   // ==========================================================================
   property p_inhibit_off;
      @(posedge mclk) disable iff (rst)
      (relay_power_inhibit_input && !q_ff.latching) |=> (relay_drive == 4'h0);
   endproperty
   a_inhibit_off: assert property (p_inhibit_off) else $error("non-latching relay not off under inhibit");

   property p_inhibit_hold;
      @(posedge mclk) disable iff (rst)
      (relay_power_inhibit_input && q_ff.latching) |=> (relay_drive == $past(relay_drive));
   endproperty
   a_inhibit_hold: assert property (p_inhibit_hold) else $error("latching relay moved under inhibit");

   property p_mismatch_masked;
      @(posedge mclk) disable iff (rst)
      relay_power_inhibit_input |=> (q_ff.mismatch == 4'h0) && q_ff.inhibited;
   endproperty
   a_mismatch_masked: assert property (p_mismatch_masked) else $error("mismatch shown while inhibited");

   property p_mismatch_seen;
      @(posedge mclk) disable iff (rst)
      (!relay_power_inhibit_input && relay_drive[0] != relay_back[0]) |=> q_ff.mismatch[0];
   endproperty
   a_mismatch_seen: assert property (p_mismatch_seen) else $error("relay disagreement not reported");

   property p_fail_on;
      @(posedge mclk) disable iff (rst)
      (!relay_power_inhibit_input && cpu_fail && q_ff.fail_state[1:0] == mio_pkg::FAIL_ON) |=> relay_drive[0];
   endproperty
   a_fail_on: assert property (p_fail_on) else $error("relay did not take its on fail state");

   property p_cos_flag;
      @(posedge mclk) disable iff (rst)
      (!q_ff.sleep && di_lvl != q_ff.di_state) |=> ((q_ff.cos_flags & $past(di_lvl ^ q_ff.di_state))
         == $past(di_lvl ^ q_ff.di_state)) && cos_event;
   endproperty
   a_cos_flag: assert property (p_cos_flag) else $error("input change left no event");

   property p_sleep_read;
      @(posedge mclk) disable iff (rst)
      (reg_rd && q_ff.sleep && reg_addr == mio_pkg::OFS_DI_STATE) |=> (reg_rdata == {16'h0, $past(q_ff.subst)});
   endproperty
   a_sleep_read: assert property (p_sleep_read) else $error("sleep read did not return substitute");

   property p_fail_report;
      @(posedge mclk) disable iff (rst)
      ($rose(module_fault) && !q_ff.fail) |=> (err_led && fail_event) ##1 (!fail_event && err_led);
   endproperty
   a_fail_report: assert property (p_fail_report) else $error("module failure not reported");
endmodule : mio_top

// [core/mio_pkg.sv]
package mio_pkg;
   // ==========================================================================
   // register offsets (byte addresses, one 32-bit word each)
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_FILT = 8'h04;
   localparam logic [7:0] OFS_CNT_EN = 8'h08;
   localparam logic [7:0] OFS_RELAY_CMD = 8'h0c;
   localparam logic [7:0] OFS_FAIL_STATE = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   localparam logic [7:0] OFS_DI_STATE = 8'h18;
   localparam logic [7:0] OFS_COS_FLAGS = 8'h1c;
   localparam logic [7:0] OFS_EVENT = 8'h20;
   localparam logic [7:0] OFS_SUBST = 8'h24;
   localparam logic [7:0] OFS_SCALE = 8'h28;
   localparam logic [7:0] OFS_RANGE = 8'h2c;
   localparam logic [7:0] OFS_RELAY_STATE = 8'h30;
   localparam logic [1:0] OFS_COUNT_PAGE = 2'h1;   // 0x40..0x6c, counter i at 0x40 + 4*i
   localparam logic [3:0] OFS_AI_PAGE = 4'h8;      // 0x80..0x8c, channel i at 0x80 + 4*i
   // ==========================================================================
   // control and status field positions
   localparam int CTRL_SLEEP = 0;
   localparam int CTRL_MAINS60 = 1;
   localparam int CTRL_AVG_LSB = 2;
   localparam int CTRL_EGU = 5;
   localparam int CTRL_LATCHING = 6;
   localparam int ST_INHIBIT = 4;
   localparam int ST_FAIL = 5;
   localparam int ST_UNDER_LSB = 6;
   localparam int ST_OVER_LSB = 10;
   localparam int ST_CPU_FAIL = 14;
   // ==========================================================================
   // reset values
   localparam logic [15:0] RST_GAIN = 16'h0100;    // unity in 8.8 fixed point
   localparam logic [15:0] RST_LO_LIM = 16'h8000;
   localparam logic [15:0] RST_HI_LIM = 16'h7fff;
   localparam logic [7:0] RST_FILT = 8'h00;
   // ==========================================================================
   // relay fail-state codes
   localparam logic [1:0] FAIL_OFF = 2'h0;
   localparam logic [1:0] FAIL_ON = 2'h1;
   localparam logic [1:0] FAIL_HOLD = 2'h2;
   // ==========================================================================
   // timing: all module time derives from one 50 us base tick
   localparam int CLK_PERIOD_PS = 5000;
   localparam int TICK_US = 50;
   localparam int TICK_CYC = (TICK_US * 1000000) / CLK_PERIOD_PS;
   localparam int DI_STEP_US = 200;
   localparam int DI_STEP_TICKS = DI_STEP_US / TICK_US;
   localparam int STAMP_US = 1000;
   localparam int STAMP_TICKS = STAMP_US / TICK_US;
   localparam int SMP50_US = 10000;
   localparam int SMP60_US = 8330;
   localparam logic [7:0] SMP50_TICKS = 8'(SMP50_US / TICK_US);
   localparam logic [7:0] SMP60_TICKS = 8'(SMP60_US / TICK_US);
endpackage : mio_pkg

// [core/mio_debounce.sv]
`timescale 1ns/10ps
module mio_debounce (
   input wire logic mclk,
   input wire logic rst,
   input wire logic tick,
   input wire logic raw,
   input wire logic [7:0] limit,
   output logic level
);
   typedef struct packed {
      logic level;
      logic [7:0] cnt;
   } mio_deb_type;

   mio_deb_type q_ff;
   mio_deb_type nxt_q;

   // ==========================================================================
   // hold-time filter: level moves only after raw held steady for limit ticks
   always_comb begin
      nxt_q = q_ff;
      if (raw == q_ff.level) begin
         nxt_q.cnt = 8'h00;                       // any bounce restarts the wait
      end else if (limit == 8'h00) begin
         nxt_q.level = raw;                       // zero filter time passes straight through
      end else if (tick) begin
         if (q_ff.cnt + 8'h01 >= limit) begin
            nxt_q.level = raw;
            nxt_q.cnt = 8'h00;
         end else begin
            nxt_q.cnt = q_ff.cnt + 8'h01;
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         q_ff <= '0;
      end else begin
         q_ff <= nxt_q;
      end
   end

   assign level = q_ff.level;

   // ==========================================================================
   property p_level_follows_raw;
      @(posedge mclk) disable iff (rst)
      (q_ff.level != $past(q_ff.level)) |-> (q_ff.level == $past(raw));
   endproperty
   a_level_follows_raw: assert property (p_level_follows_raw) else $error("filtered level took a value raw never had");

   property p_no_early_change;
      @(posedge mclk) disable iff (rst)
      (limit != 8'h00 && !tick && raw != q_ff.level) |=> $stable(q_ff.level);
   endproperty
   a_no_early_change: assert property (p_no_early_change) else $error("filtered level moved without a tick");
endmodule : mio_debounce

// [tb/mio_host.sv]
`timescale 1ns/10ps
// =====================================
// cpu model: one strobe per call, never waits
module mio_host (
   input wire logic mclk,
   output logic [7:0] reg_addr,
   output logic [31:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [31:0] reg_rdata
);
   // idle bus from time zero
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : wr
   // data stands only in the cycle after the strobe, so take it mid-cycle
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(negedge mclk);
      v = reg_rdata;
   endtask : rd
endmodule : mio_host

// [tb/mio_top_tb.sv]
`timescale 1ns/10ps
module mio_top_tb;
   logic mclk, rst, inh, cpuf, mflt, wr, rd, led, fev, cev, seen;
   logic [15:0] di, sub;
   logic [3:0] back, drv, urf, orf;
   logic [3:0][15:0] adc;
   logic [7:0] addr;
   logic [31:0] wd, rdat, d, r;
   logic [31:0] seed = 32'h2b09;
   int n_errors = 0;
   int cmp_count = 0;
   int m_cmd, m_fs, m_lat, m_inh, m_cpf, m_drv, low;
   // short tick keeps filter and sample times small
   mio_top #(.TICK_CYC(4)) u_mio_top (.mclk(mclk), .rst(rst), .di_raw(di), .relay_back(back),
      .relay_power_inhibit_input(inh), .cpu_fail(cpuf), .module_fault(mflt), .adc_data(adc),
      .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat),
      .relay_drive(drv), .err_led(led), .fail_event(fev), .cos_event(cev),
      .under_range_flag(urf), .over_range_flag(orf));
   mio_host u_mio_host (.mclk(mclk), .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr),
      .reg_rd(rd), .reg_rdata(rdat));
   // =====================================
   // helpers
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic chkr(input logic [7:0] a, input logic [31:0] exp);
      u_mio_host.rd(a, d);
      chk(d, exp);
   endtask : chkr
   // relay model: inhibit first, then cpu fail, then command; hold keeps last
   task automatic upd();
      for (int i = 0; i < 4; i++) begin
         if (m_inh != 0) m_drv[i] = m_lat[0] & m_drv[i];
         else if (m_cpf == 0) m_drv[i] = m_cmd[i];
         else if (m_fs[2*i+1] == 0) m_drv[i] = m_fs[2*i];
      end
   endtask : upd
   task automatic stop_test();
      if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : stop_test
   // =====================================
   // clock, watchdog, stimulus
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   initial begin
      #60us;
      n_errors++;
      stop_test();
   end
   initial begin
      {rst, inh, cpuf, mflt, di, back, adc} = {4'h8, 16'h0, 4'h0, 64'h0};
      {m_cmd, m_fs, m_lat, m_inh, m_cpf, m_drv} = '0;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      repeat (12) begin
         r = rnd();
         @(posedge mclk);
         {cpuf, inh, back} <= {r[17:16], r[7:4]};
         m_cpf = r[17];
         m_inh = r[16];
         upd();
         u_mio_host.wr(mio_pkg::OFS_CTRL, {25'h0, r[18], 6'h0});
         m_lat = r[18];
         upd();
         u_mio_host.wr(mio_pkg::OFS_FAIL_STATE, {24'h0, r[15:8]});
         m_fs = r[15:8];
         upd();
         u_mio_host.wr(mio_pkg::OFS_RELAY_CMD, {28'h0, r[3:0]});
         m_cmd = r[3:0];
         upd();
         repeat (3) @(posedge mclk);
         chk(drv, m_drv[3:0]);
         chkr(mio_pkg::OFS_STATUS, {cpuf, 8'h0, 1'b0, inh, m_inh ? 4'h0 : m_drv[3:0] ^ back});
      end
      chkr(mio_pkg::OFS_RELAY_STATE, {24'h0, back, m_drv[3:0]});
      u_mio_host.wr(mio_pkg::OFS_FILT, 32'h2);
      r = rnd() | 32'h8000;
      for (int i = 15; i >= 0; i--) if (r[i]) low = i;
      @(posedge mclk) di <= r[15:0];
      repeat (5) @(posedge mclk);
      di <= 16'h0;
      repeat (40) @(posedge mclk);
      chkr(mio_pkg::OFS_DI_STATE, 32'h0);
      @(posedge mclk) di <= r[15:0];
      repeat (60) @(posedge mclk);
      chkr(mio_pkg::OFS_DI_STATE, {16'h0, r[15:0]});
      chk(cev, 1'b1);
      u_mio_host.rd(mio_pkg::OFS_EVENT, d);
      chk(d[19:16], low);
      u_mio_host.wr(mio_pkg::OFS_COS_FLAGS, 32'hffff);
      repeat (4) @(posedge mclk);
      chk(cev, 1'b0);
      di <= 16'h0;
      u_mio_host.wr(mio_pkg::OFS_CNT_EN, 32'hfff);
      // counter filter of two ticks must swallow a one-cycle glitch
      u_mio_host.wr(mio_pkg::OFS_FILT, 32'h202);
      @(posedge mclk) di <= 16'hffff;
      @(posedge mclk) di <= 16'h0;
      repeat (3) begin
         @(posedge mclk) di <= 16'hffff;
         repeat (20) @(posedge mclk);
         di <= 16'h0;
         repeat (20) @(posedge mclk);
      end
      chkr(8'h40, 32'h3);
      chkr(8'h6c, 32'h3);
      chkr(8'h70, 32'h0);
      sub = 16'(rnd());
      u_mio_host.wr(mio_pkg::OFS_SUBST, {16'h0, sub});
      u_mio_host.wr(mio_pkg::OFS_CTRL, 32'h1);
      for (int i = 0; i < 4; i++) chkr(i == 3 ? 8'h88 : 8'h18 << i, {16'h0, sub});
      @(posedge mclk) mflt <= 1'b1;
      seen = 1'b0;
      repeat (5) @(posedge mclk) seen |= fev;
      chk({seen, led}, 2'h3);
      u_mio_host.rd(mio_pkg::OFS_STATUS, d);
      chk(d[5], 1'b1);
      // analog: window of one, under range from a negative input
      u_mio_host.wr(mio_pkg::OFS_RANGE, 32'h0100_0010);
      adc <= {4{16'hfff0}};
      u_mio_host.wr(mio_pkg::OFS_CTRL, 32'h0);
      repeat (1000) @(posedge mclk);
      chk({orf, urf}, 8'h0f);
      u_mio_host.rd(8'h80, d);
      chk(d[15:0], 16'hfff0);
      u_mio_host.wr(mio_pkg::OFS_SCALE, 32'h0001_0200);
      adc <= {4{16'h0200}};
      u_mio_host.wr(mio_pkg::OFS_CTRL, 32'h20);
      repeat (1000) @(posedge mclk);
      chk({orf, urf}, 8'hf0);
      chkr(8'h84, 32'h401);
      // 60 Hz with a window of two: a restarted window halves its first sample
      u_mio_host.wr(mio_pkg::OFS_RANGE, 32'h0180_8000);
      u_mio_host.wr(mio_pkg::OFS_CTRL, 32'h6);
      low = 0;
      while (orf[0] && low < 2000) begin
         @(posedge mclk);
         low++;
      end
      low = 0;
      while (!orf[0] && low < 2000) begin
         @(posedge mclk);
         low++;
      end
      chk(low, 32'(mio_pkg::SMP60_TICKS) * 32'h4);
      chkr(8'h80, 32'h200);
      @(posedge mclk) adc <= '0;
      low = 0;
      while (orf[0] && low < 2000) begin
         @(posedge mclk);
         low++;
      end
      chkr(8'h80, 32'h100);
      stop_test();
   end
endmodule : mio_top_tb
